// ===== axis_input_pkg.sv
package axis_input_pkg;
    localparam int num_axes = 4;
    localparam int num_gen = 4;
    // Register byte offsets
    localparam logic [7:0] off_cfg0 = 8'h00;
    localparam logic [7:0] off_cfg1 = 8'h04;
    localparam logic [7:0] off_cfg2 = 8'h08;
    localparam logic [7:0] off_cfg3 = 8'h0c;
    localparam logic [7:0] off_stat = 8'h10;
    localparam logic [7:0] off_inp = 8'h14;
    localparam logic [7:0] off_irq_stat = 8'h18;
    localparam logic [7:0] off_irq_en = 8'h1c;
    localparam logic [7:0] off_irq_clr = 8'h20;
    localparam logic [7:0] off_cmd = 8'h24;
    // Per-axis config word fields
    localparam int f_inpos_en = 0;
    localparam int f_inpos_pol = 1;
    localparam int f_alarm_en = 2;
    localparam int f_alarm_pol = 3;
    localparam int f_plim_en = 4;
    localparam int f_plim_pol = 5;
    localparam int f_mlim_en = 6;
    localparam int f_mlim_pol = 7;
    localparam int f_lim_sudden = 8;
    localparam int f_gen_en = 9;
    localparam int f_gen_pol = 13;
    localparam int f_gen_sudden = 17;
    localparam int f_ext_mode = 18;
    // Per-axis status byte fields
    localparam int s_drv = 0;
    localparam int s_alarm = 1;
    localparam int s_plim = 2;
    localparam int s_mlim = 3;
    localparam int s_emg = 4;
    localparam int s_stop = 5;
    // Command word fields: bit0 start, bit1 minus, bit2 stop
    localparam int c_start = 0;
    localparam int c_minus = 1;
    localparam int c_stop = 2;
    localparam int c_axis = 4;
    localparam logic [1:0] ext_off = 2'h0;
    localparam logic [1:0] ext_fixed = 2'h1;
    localparam logic [1:0] ext_cont = 2'h2;
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
    localparam int stat_bits = 8;
endpackage

// ===== axis_input_stop.sv
`timescale 1ns/1ps
module axis_input_stop (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [axis_input_pkg::num_axes-1:0] servo_in_position,
    input wire logic [axis_input_pkg::num_axes-1:0] servo_fault_input,
    input wire logic [axis_input_pkg::num_axes-1:0] plus_over_limit,
    input wire logic [axis_input_pkg::num_axes-1:0] minus_over_limit,
    input wire logic [axis_input_pkg::num_axes*axis_input_pkg::num_gen-1:0] general_stop_inputs,
    input wire logic [axis_input_pkg::num_axes-1:0] ext_plus_start,
    input wire logic [axis_input_pkg::num_axes-1:0] ext_minus_start,
    input wire logic emergency_stop_n,
    input wire logic [axis_input_pkg::num_axes-1:0] pulse_busy,
    input wire logic [axis_input_pkg::num_axes-1:0] pulse_dir_minus,
    output logic [axis_input_pkg::num_axes-1:0] start_plus,
    output logic [axis_input_pkg::num_axes-1:0] start_minus,
    output logic [axis_input_pkg::num_axes-1:0] decel_stop,
    output logic [axis_input_pkg::num_axes-1:0] sudden_stop,
    output logic [axis_input_pkg::num_axes-1:0] axis_driving_flag,
    output logic irq
);
    import axis_input_pkg::*;

    localparam int na = num_axes;
    localparam int nev = 3 * na + 1;
    // Register index bits of a byte address
    localparam int idx_lsb = 2;
    localparam int idx_w = 2;

    // =====================================================
    // State
    typedef struct packed {
        // Write slot
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;

        // Read slot
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;

        // Software registers
        logic [na-1:0][31:0] cfg;
        logic [nev-1:0] irq_stat;
        logic [nev-1:0] irq_en;

        // Input history and axis state
        logic [na-1:0] busy_d;
        logic [na-1:0] drv;
        logic [na-1:0] exp_d;
        logic [na-1:0] exm_d;

        // One-cycle requests to the pulse generator
        logic [na-1:0] stp;
        logic [na-1:0] stm;
        logic [na-1:0] dec;
        logic [na-1:0] sud;

        // Status bytes and general stop levels
        logic [na-1:0][stat_bits-1:0] stat;
        logic [na*num_gen-1:0] gen_lvl;
    } state_s;

    state_s state_reg;
    state_s state_next;

    // =====================================================
    // Helpers
    function automatic logic act(input logic lvl, input logic pol);
        act = (lvl == pol);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
        merge = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                merge[b*8 +: 8] = d[b*8 +: 8];
            end
        end
    endfunction

    // Config word selected by a byte address
    function automatic logic [idx_w-1:0] word_index(input logic [7:0] addr);
        word_index = addr[idx_lsb +: idx_w];
    endfunction

    // Interrupt field padded to a bus word
    function automatic logic [31:0] irq_word(input logic [nev-1:0] bits);
        irq_word = {{(32-nev){1'b0}}, bits};
    endfunction

    // High now, low in the previous cycle
    function automatic logic went_high(input logic now, input logic was);
        went_high = now && !was;
    endfunction

    // Low now, high in the previous cycle
    function automatic logic went_low(input logic now, input logic was);
        went_low = was && !now;
    endfunction

    // =====================================================
    // Next state
    always_comb begin
        logic wr;
        logic emergency_flag;
        logic [1:0] ax;
        logic [1:0] emode;
        logic al;
        logic pl;
        logic ml;
        logic ip;
        logic gstop;
        logic gsud;
        logic lim_hit;
        logic [nev-1:0] ev;
        logic [31:0] rd;

        wr = 1'b0;
        emergency_flag = 1'b0;
        ax = 2'h0;
        emode = 2'h0;
        al = 1'b0;
        pl = 1'b0;
        ml = 1'b0;
        ip = 1'b0;
        gstop = 1'b0;
        gsud = 1'b0;
        lim_hit = 1'b0;
        ev = '0;
        rd = '0;

        // Pulses drop each cycle, input history follows the pins
        state_next = state_reg;
        state_next.stp = '0;
        state_next.stm = '0;
        state_next.dec = '0;
        state_next.sud = '0;
        state_next.busy_d = pulse_busy;
        state_next.exp_d = ext_plus_start;
        state_next.exm_d = ext_minus_start;
        state_next.gen_lvl = general_stop_inputs;

        // =====================================================
        // Bus write channel
        // Each channel latches once and waits for its partner
        if (s_axi_awvalid && !state_reg.aw_got) begin
            state_next.aw_got = 1'b1;
            state_next.awaddr = s_axi_awaddr;
        end

        if (s_axi_wvalid && !state_reg.w_got) begin
            state_next.w_got = 1'b1;
            state_next.wdata = s_axi_wdata;
            state_next.wstrb = s_axi_wstrb;
        end

        wr = state_reg.aw_got && state_reg.w_got && !state_reg.bvalid;
        if (s_axi_bvalid && s_axi_bready) begin
            state_next.bvalid = 1'b0;
        end

        emergency_flag = !emergency_stop_n;
        if (wr) begin
            state_next.aw_got = 1'b0;
            state_next.w_got = 1'b0;
            state_next.bvalid = 1'b1;
            state_next.bresp = resp_okay;
            case (state_reg.awaddr)
                off_cfg0, off_cfg1, off_cfg2, off_cfg3: begin
                    ax = word_index(state_reg.awaddr);
                    state_next.cfg[ax] = merge(state_reg.cfg[ax], state_reg.wdata,
                                               state_reg.wstrb);
                end
                off_irq_en: state_next.irq_en = state_reg.wdata[nev-1:0];
                off_irq_clr: state_next.irq_stat = state_reg.irq_stat & ~state_reg.wdata[nev-1:0];
                off_cmd: begin
                    ax = state_reg.wdata[c_axis +: idx_w];
                    // A stop request wins over a start in one command
                    if (state_reg.wdata[c_stop]) begin
                        state_next.dec[ax] = 1'b1;
                    end else if (state_reg.wdata[c_start] && !emergency_flag) begin
                        state_next.stp[ax] = !state_reg.wdata[c_minus];
                        state_next.stm[ax] = state_reg.wdata[c_minus];
                    end
                end
                // Read-only words accept and ignore writes
                off_stat, off_inp, off_irq_stat: state_next.bresp = resp_okay;
                default: state_next.bresp = resp_slverr;
            endcase
        end

        // =====================================================
        // Per-axis input handling
        for (int a = 0; a < na; a++) begin
            al = state_reg.cfg[a][f_alarm_en] &&
                 act(servo_fault_input[a], state_reg.cfg[a][f_alarm_pol]);
            pl = state_reg.cfg[a][f_plim_en] &&
                 act(plus_over_limit[a], state_reg.cfg[a][f_plim_pol]);
            ml = state_reg.cfg[a][f_mlim_en] &&
                 act(minus_over_limit[a], state_reg.cfg[a][f_mlim_pol]);
            ip = act(servo_in_position[a], state_reg.cfg[a][f_inpos_pol]);
            gstop = 1'b0;
            for (int g = 0; g < num_gen; g++) begin
                gstop = gstop || (state_reg.cfg[a][f_gen_en + g] &&
                        act(general_stop_inputs[a*num_gen + g], state_reg.cfg[a][f_gen_pol + g]));
            end
            gsud = state_reg.cfg[a][f_gen_sudden];

            // Status levels, one cycle behind the pins
            state_next.stat[a][s_alarm] = al;
            state_next.stat[a][s_plim] = pl;
            state_next.stat[a][s_mlim] = ml;
            state_next.stat[a][s_emg] = emergency_flag;
            state_next.stat[a][s_stop] = gstop;

            // Interrupt events on rising alarm and limit conditions and on falling busy
            ev[3*a] = went_high(al, state_reg.stat[a][s_alarm]);
            ev[3*a+1] = went_high(pl, state_reg.stat[a][s_plim]) ||
                        went_high(ml, state_reg.stat[a][s_mlim]);
            ev[3*a+2] = went_low(pulse_busy[a], state_reg.busy_d[a]);

            // Limit stop only in the matching direction
            lim_hit = pulse_busy[a] && ((pl && !pulse_dir_minus[a]) ||
                                        (ml && pulse_dir_minus[a]));
            if (lim_hit) begin
                if (state_reg.cfg[a][f_lim_sudden]) begin
                    state_next.sud[a] = 1'b1;
                end else begin
                    state_next.dec[a] = 1'b1;
                end
            end

            // General stops act in either direction
            if (pulse_busy[a] && gstop) begin
                if (gsud) begin
                    state_next.sud[a] = 1'b1;
                end else begin
                    state_next.dec[a] = 1'b1;
                end
            end

            // Emergency overrides every other stop
            if (emergency_flag) begin
                state_next.sud[a] = 1'b1;
                state_next.dec[a] = 1'b0;
            end

            // External start only while the axis is idle
            emode = state_reg.cfg[a][f_ext_mode +: 2];
            if (!emergency_flag && !pulse_busy[a]) begin
                if (emode == ext_fixed) begin
                    state_next.stp[a] = went_low(ext_plus_start[a], state_reg.exp_d[a]);
                    state_next.stm[a] = went_low(ext_minus_start[a], state_reg.exm_d[a]);
                end else if (emode == ext_cont) begin
                    state_next.stp[a] = !ext_plus_start[a];
                    state_next.stm[a] = ext_minus_start[a] ? 1'b0 : ext_plus_start[a];
                end
                if (state_next.stp[a] && state_next.stm[a]) begin
                    state_next.stm[a] = 1'b0;
                end
            end

            // Driving flag held until in-position or emergency
            if (pulse_busy[a]) begin
                state_next.drv[a] = 1'b1;
            end else if (!state_reg.cfg[a][f_inpos_en] || ip || emergency_flag) begin
                state_next.drv[a] = 1'b0;
            end
            state_next.stat[a][s_drv] = state_next.drv[a];
        end
        // Emergency onset is one event for all axes
        ev[nev-1] = went_high(emergency_flag, state_reg.stat[0][s_emg]);
        // Set beats clear
        state_next.irq_stat = state_next.irq_stat | ev;

        // =====================================================
        // Bus read channel
        if (s_axi_rvalid && s_axi_rready) begin
            state_next.rvalid = 1'b0;
        end

        if (s_axi_arvalid && !state_reg.rvalid) begin
            state_next.rvalid = 1'b1;
            state_next.rresp = resp_okay;
            case (s_axi_araddr)
                off_cfg0, off_cfg1, off_cfg2, off_cfg3: rd = state_reg.cfg[word_index(s_axi_araddr)];
                off_stat: rd = state_reg.stat;
                off_inp: rd = {{(32-na*num_gen){1'b0}}, state_reg.gen_lvl};
                off_irq_stat: rd = irq_word(state_reg.irq_stat);
                off_irq_en: rd = irq_word(state_reg.irq_en);
                off_irq_clr, off_cmd: rd = '0;
                default: state_next.rresp = resp_slverr;
            endcase
            state_next.rdata = rd;
        end

        // Synchronous reset clears every field
        if (!aresetn) begin
            state_next = '0;
        end
    end

    // =====================================================
    // State register
    always_ff @(posedge aclk) begin
        state_reg <= state_next;
    end

    // =====================================================
    // Bus outputs
    assign s_axi_awready = !state_reg.aw_got;
    assign s_axi_wready = !state_reg.w_got;
    assign s_axi_bvalid = state_reg.bvalid;
    assign s_axi_bresp = state_reg.bresp;
    assign s_axi_arready = !state_reg.rvalid;
    assign s_axi_rvalid = state_reg.rvalid;
    assign s_axi_rdata = state_reg.rdata;
    assign s_axi_rresp = state_reg.rresp;

    // =====================================================
    // Axis outputs
    assign start_plus = state_reg.stp;
    assign start_minus = state_reg.stm;
    assign decel_stop = state_reg.dec;
    assign sudden_stop = state_reg.sud;
    assign axis_driving_flag = state_reg.drv;

    // =====================================================
    // Interrupt line
    assign irq = |(state_reg.irq_stat & state_reg.irq_en);
endmodule // axis_input_stop

// ===== axis_input_stop_monitor.sv
`timescale 1ns/1ps
module axis_input_stop_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic emergency_stop_n,
    input wire logic [axis_input_pkg::num_axes-1:0] pulse_busy,
    input wire logic [axis_input_pkg::num_axes-1:0] start_plus,
    input wire logic [axis_input_pkg::num_axes-1:0] start_minus,
    input wire logic [axis_input_pkg::num_axes-1:0] sudden_stop,
    input wire logic [axis_input_pkg::num_axes-1:0] axis_driving_flag
);
    import axis_input_pkg::*;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ==========
    // Emergency, driving flag, starts
    a_emg_sudden: assert property (!emergency_stop_n |=> &sudden_stop)
        else $error("emergency without sudden stop");
    a_emg_no_start: assert property (
        !emergency_stop_n |=> (start_plus | start_minus) == '0)
        else $error("start during emergency");
    a_emg_drv_clear: assert property (
        !emergency_stop_n |=> (axis_driving_flag & ~$past(pulse_busy)) == '0)
        else $error("driving flag kept in emergency");
    a_busy_drv: assert property (
        1'h1 |=> (axis_driving_flag & $past(pulse_busy)) == $past(pulse_busy))
        else $error("driving flag low while busy");
    a_start_excl: assert property ((start_plus & start_minus) == '0)
        else $error("both directions started");
    // ==========
    // Register bus
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_wr_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
        else $error("write answer late");
    a_aw_single: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("second write address taken");
    c_emg: cover property (!emergency_stop_n ##1 &sudden_stop);
    c_start: cover property (|start_plus);
    c_write: cover property (s_axi_bvalid);
endmodule // axis_input_stop_monitor
bind axis_input_stop axis_input_stop_monitor mon (.*);

// ===== axis_far_side.sv
`timescale 1ns/1ps
module axis_far_side (
    input wire logic aclk,
    input wire logic emg_req,
    input wire logic [7:0] servo_req,
    input wire logic [23:0] stop_req,
    input wire logic [7:0] start_req,
    output logic emergency_stop_n,
    output logic [3:0] servo_in_position,
    output logic [3:0] servo_fault_input,
    output logic [3:0] plus_over_limit,
    output logic [3:0] minus_over_limit,
    output logic [15:0] general_stop_inputs,
    output logic [3:0] ext_plus_start,
    output logic [3:0] ext_minus_start
);
    logic [1:0] hold_reg = 2'h0;
    // ==========
    // Stretch a short low request past two clocks
    always @(posedge aclk) begin
        if (!emg_req)
            hold_reg <= 2'h2;
        else if (hold_reg != 2'h0)
            hold_reg <= hold_reg - 2'h1;
    end
    assign emergency_stop_n = emg_req && hold_reg == 2'h0;
    assign {servo_fault_input, servo_in_position} = servo_req;
    assign {general_stop_inputs, minus_over_limit, plus_over_limit} = stop_req;
    assign {ext_minus_start, ext_plus_start} = start_req;
endmodule // axis_far_side

// ===== axis_input_stop_logic_tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module axis_input_stop_logic_tb_top;
    import axis_input_pkg::*;
    logic aclk = 1'h0, aresetn = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [3:0] servo_in_position, servo_fault_input, plus_over_limit, minus_over_limit;
    logic [3:0] ext_plus_start, ext_minus_start, start_plus, start_minus, cnt;
    logic [3:0] decel_stop, sudden_stop, axis_driving_flag;
    logic [3:0] pulse_busy = 4'h0, pulse_dir_minus = 4'h0;
    logic [15:0] general_stop_inputs;
    logic emergency_stop_n, emg_req = 1'h1;
    logic [7:0] servo_req = 8'h00, start_req = 8'hff;
    logic [23:0] stop_req = 24'h0;
    int failures = 0, tests_run = 0;

    always #5 aclk = ~aclk;
    axis_input_stop dut (.*);
    axis_far_side far (.*);

    // ==========
    // Bus access
    task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
        int n;
        logic hx, hw, hb;
        n = 0;
        hb = 1'h0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_arvalid, s_axi_rready} <= {2{rd}};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{!rd}};
        while (!hb && n < 50) begin
            @(negedge aclk);
            hx = rd ? s_axi_arvalid && s_axi_arready : s_axi_awvalid && s_axi_awready;
            hw = s_axi_wvalid && s_axi_wready;
            hb = rd ? s_axi_rvalid && s_axi_rready : s_axi_bvalid && s_axi_bready;
            q = s_axi_rdata;
            r = rd ? s_axi_rresp : s_axi_bresp;
            @(posedge aclk);
            if (hx && rd) s_axi_arvalid <= 1'h0;
            if (hx && !rd) s_axi_awvalid <= 1'h0;
            if (hw) s_axi_wvalid <= 1'h0;
            if (hb) {s_axi_bready, s_axi_rready} <= 2'h0;
            n++;
        end
        if (!hb) begin
            failures++;
            tally_and_finish();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'h0, a, d);
        `CHK(r, resp_okay)
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'h1, a, 32'h0);
        `CHK({r, q}, {resp_okay, e})
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask
    task automatic starts(input int dir, input int skip);
        cnt = 4'h0;
        repeat (skip) @(negedge aclk);
        for (int i = 0; i < 8; i++) begin
            @(negedge aclk);
            cnt = cnt + {3'h0, dir == 2 ? decel_stop[1] : dir ? start_minus[0] : start_plus[0]};
        end
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ==========
    // Scenarios
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        rdchk(off_cfg0, 32'h0);
        wr(off_cfg0, 32'h23ff);
        rdchk(off_cfg0, 32'h23ff);
        bus(1'h1, 8'h40, 32'h0);
        `CHK({r, q}, {resp_slverr, 32'h0})
        done("registers");
        servo_req <= 8'h10;
        stop_req <= 24'h11;
        rdchk(off_stat, 32'h0e);
        done("status");
        @(posedge aclk);
        servo_req <= 8'h00;
        pulse_busy <= 4'h1;
        stop_req <= 24'h01;
        settle(3);
        `CHK({decel_stop[0], sudden_stop[0]}, 2'h1)
        @(posedge aclk);
        pulse_dir_minus <= 4'h1;
        settle(3);
        `CHK({decel_stop[0], sudden_stop[0]}, 2'h0)
        wr(off_cfg0, 32'h22ff);
        stop_req <= 24'h10;
        settle(3);
        `CHK({decel_stop[0], sudden_stop[0]}, 2'h2)
        @(posedge aclk);
        stop_req <= 24'h100;
        settle(3);
        `CHK({decel_stop[0], sudden_stop[0]}, 2'h2)
        rdchk(off_inp, 32'h1);
        done("stops");
        stop_req <= 24'h0;
        pulse_busy <= 4'h0;
        settle(3);
        `CHK(axis_driving_flag[0], 1'h1)
        @(posedge aclk);
        servo_req <= 8'h01;
        settle(3);
        `CHK(axis_driving_flag[0], 1'h0)
        done("in-position");
        fork
            wr(off_cmd, 32'h3);
            starts(1, 0);
        join
        `CHK(cnt, 4'h1)
        fork
            wr(off_cmd, 32'h14);
            starts(2, 0);
        join
        `CHK(cnt, 4'h1)
        done("commands");
        for (int m = 1; m <= 2; m++) begin
            for (int dir = 0; dir < 2; dir++) begin
                wr(off_cfg0, 32'h22ff | (m << f_ext_mode));
                start_req[dir*4] <= 1'h0;
                starts(dir, m == 2 ? 3 : 0);
                `CHK(cnt, m == 2 ? 4'h8 : 4'h1)
                @(posedge aclk);
                start_req <= 8'hff;
            end
        end
        done("external starts");
        wr(off_irq_en, 32'h1000);
        emg_req <= 1'h0;
        settle(3);
        `CHK({irq, sudden_stop}, 5'h1f)
        rdchk(off_stat, 32'h10101010);
        @(posedge aclk);
        emg_req <= 1'h1;
        wr(off_irq_en, 32'h0);
        settle(0);
        `CHK({irq, sudden_stop}, 5'h00)
        wr(off_irq_en, 32'h1000);
        settle(0);
        `CHK(irq, 1'h1)
        wr(off_irq_clr, 32'h1000);
        settle(0);
        `CHK(irq, 1'h0)
        done("emergency");
        tally_and_finish();
    end
endmodule // axis_input_stop_logic_tb_top
